// ==== rtl/aot_pkg.sv ====
package aot_pkg;
    // Register map of the trim bank, byte addresses on the internal register port
    localparam logic [7:0] ADDR_X_TRIM   = 8'h2f;
    localparam logic [7:0] ADDR_Y_TRIM   = 8'h30;
    localparam logic [7:0] ADDR_Z_TRIM   = 8'h31;
    localparam logic [7:0] TRIM_RESET    = 8'h00;
    localparam int         NUM_AXES      = 3;
    localparam int         TRIM_W        = 8;
    // Correction weight per trim count, in mg
    localparam int         TRIM_MG_PER_LSB = 2;
    // Default sample weight in mg per count (2 g range at 12 bits is 1 mg)
    localparam int         SAMPLE_MG_PER_LSB = 1;
    localparam int         SAMPLE_W      = 12;
endpackage

// ==== rtl/aot_axis_offset_trim.sv ====
`timescale 1ns/1ps
module aot_axis_offset_trim #(
    parameter int SAMPLE_W  = aot_pkg::SAMPLE_W,
    parameter int MG_PER_LSB = aot_pkg::SAMPLE_MG_PER_LSB
) (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_resetn,
    input  wire logic [7:0]            i_reg_addr,
    input  wire logic                  i_reg_wr,
    input  wire logic [7:0]            i_reg_wdata,
    output logic      [7:0]            o_reg_rdata,
    output logic                       o_reg_hit,
    input  wire logic                  i_smp_valid,
    input  wire logic [3*SAMPLE_W-1:0] i_smp_raw,
    output logic                       o_smp_valid,
    output logic      [3*SAMPLE_W-1:0] o_smp_trim
);
    import aot_pkg::*;

    // Trim counts scaled to sample counts; limited to integer ratios
    localparam int SCALE = TRIM_MG_PER_LSB / MG_PER_LSB;

    logic [TRIM_W-1:0]     trim_q [NUM_AXES];
    logic [NUM_AXES-1:0]   sel;
    logic                  smp_valid_q;
    logic [3*SAMPLE_W-1:0] smp_q;

    // Address decode of the three trim slots
    assign sel[0]    = (i_reg_addr == ADDR_X_TRIM);
    assign sel[1]    = (i_reg_addr == ADDR_Y_TRIM);
    assign sel[2]    = (i_reg_addr == ADDR_Z_TRIM);
    assign o_reg_hit = |sel;
    // Unmapped addresses read zero so the wider map can OR results together
    assign o_reg_rdata = sel[0] ? trim_q[0] :
                         sel[1] ? trim_q[1] :
                         sel[2] ? trim_q[2] : 8'h00;

    genvar g;
    generate
        for (g = 0; g < NUM_AXES; g++) begin : g_axis
            logic signed [SAMPLE_W+1:0] raw_ext;
            logic signed [SAMPLE_W+1:0] adj_ext;
            logic signed [SAMPLE_W+1:0] sum;
            logic signed [SAMPLE_W-1:0] sat;

            // Trim register per axis
            always_ff @(posedge i_sys_clk) begin
                if (!i_resetn) begin
                    trim_q[g] <= TRIM_RESET;
                end else if (i_reg_wr && sel[g]) begin
                    trim_q[g] <= i_reg_wdata;
                end
            end

            // Sign-extend both, scale trim; +/-128 counts x 2 mg gives about +/-256 mg
            assign raw_ext = (SAMPLE_W+2)'(signed'(i_smp_raw[g*SAMPLE_W +: SAMPLE_W]));
            assign adj_ext = (SAMPLE_W+2)'(signed'(trim_q[g]) * SCALE);
            assign sum     = raw_ext + adj_ext;
            // Saturate rather than wrap, so a large trim cannot flip the sign
            assign sat = (sum > (SAMPLE_W+2)'(2**(SAMPLE_W-1)-1)) ?
                             SAMPLE_W'(2**(SAMPLE_W-1)-1) :
                         (sum < -(SAMPLE_W+2)'(2**(SAMPLE_W-1))) ?
                             SAMPLE_W'(-(2**(SAMPLE_W-1))) : sum[SAMPLE_W-1:0];

            // Corrected sample register
            always_ff @(posedge i_sys_clk) begin
                if (!i_resetn) begin
                    smp_q[g*SAMPLE_W +: SAMPLE_W] <= '0;
                end else if (i_smp_valid) begin
                    smp_q[g*SAMPLE_W +: SAMPLE_W] <= sat;
                end
            end
        end
    endgenerate

    // Valid follows the sample one cycle later
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            smp_valid_q <= 1'b0;
        end else begin
            smp_valid_q <= i_smp_valid;
        end
    end

    assign o_smp_valid = smp_valid_q;
    assign o_smp_trim  = smp_q;

    a_trim_write_x: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_reg_wr && sel[0] |=> trim_q[0] == $past(i_reg_wdata))
        else $error("x trim not stored");
    a_trim_reset_zero: assert property (@(posedge i_sys_clk)
        !i_resetn |=> (trim_q[0] == 8'h00 && trim_q[1] == 8'h00 && trim_q[2] == 8'h00))
        else $error("trim not zero after reset");
    a_trim_readback: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_reg_wr && sel[2] ##1 !i_reg_wr && sel[2] |-> o_reg_rdata == $past(i_reg_wdata))
        else $error("z trim readback wrong");
    a_zero_trim_pass: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_smp_valid && trim_q[1] == 8'h00 && !(i_reg_wr && sel[1])
        |=> o_smp_trim[SAMPLE_W +: SAMPLE_W] == $past(i_smp_raw[SAMPLE_W +: SAMPLE_W]))
        else $error("zero trim altered y sample");
    a_valid_delay: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_smp_valid |=> o_smp_valid)
        else $error("valid not forwarded");
    a_hold_no_valid: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        !i_smp_valid |=> $stable(o_smp_trim))
        else $error("sample changed without valid");
    a_trim_signed_x: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_smp_valid && i_smp_raw[SAMPLE_W-1:0] == '0 && trim_q[0] == 8'hff
        |=> o_smp_trim[SAMPLE_W-1:0] == SAMPLE_W'(-SCALE))
        else $error("negative trim not signed");
    a_trim_scale_z: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_smp_valid && i_smp_raw[3*SAMPLE_W-1 -: SAMPLE_W] == '0 && trim_q[2] == 8'h7f
        |=> o_smp_trim[3*SAMPLE_W-1 -: SAMPLE_W] == SAMPLE_W'(127 * SCALE))
        else $error("trim scale wrong");

    // Y slot stores what the host wrote
    a_trim_write_y: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_reg_wr && sel[1] |=> trim_q[1] == $past(i_reg_wdata))
        else $error("y trim not stored");

    // Separate slot so a decode slip onto Z shows up here
    a_trim_write_z: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_reg_wr && sel[2] |=> trim_q[2] == $past(i_reg_wdata))
        else $error("z trim not stored");

    // A trim only moves when its own slot is written
    a_trim_hold_x: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        !(i_reg_wr && sel[0]) |=> $stable(trim_q[0]))
        else $error("x trim changed without write");

    // Writes to a neighbour must not leak into Y
    a_trim_hold_y: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        !(i_reg_wr && sel[1]) |=> $stable(trim_q[1]))
        else $error("y trim changed without write");

    // Writes to a neighbour must not leak into Z
    a_trim_hold_z: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        !(i_reg_wr && sel[2]) |=> $stable(trim_q[2]))
        else $error("z trim changed without write");

    // Host reads back the X byte it just wrote
    a_readback_x: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_reg_wr && sel[0] ##1 !i_reg_wr && sel[0] |-> o_reg_rdata == $past(i_reg_wdata))
        else $error("x trim readback wrong");

    // Host reads back the Y byte it just wrote
    a_readback_y: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_reg_wr && sel[1] ##1 !i_reg_wr && sel[1] |-> o_reg_rdata == $past(i_reg_wdata))
        else $error("y trim readback wrong");

    // Hit flag covers exactly the three trim addresses
    a_hit_decode: assert property (@(posedge i_sys_clk)
        o_reg_hit == (i_reg_addr == ADDR_X_TRIM || i_reg_addr == ADDR_Y_TRIM ||
                      i_reg_addr == ADDR_Z_TRIM))
        else $error("hit decode wrong");

    // Other addresses read zero so the wider map can merge read data
    a_unmapped_zero: assert property (@(posedge i_sys_clk)
        !o_reg_hit |-> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    // No stale strobe leaves the block after reset
    a_valid_reset: assert property (@(posedge i_sys_clk)
        !i_resetn |=> !o_smp_valid)
        else $error("valid high after reset");

    // Corrected sample is cleared by reset
    a_sample_reset: assert property (@(posedge i_sys_clk)
        !i_resetn |=> o_smp_trim == '0)
        else $error("sample not zero after reset");

    // One output strobe per input strobe, never stretched
    a_valid_single: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        !i_smp_valid |=> !o_smp_valid)
        else $error("valid without strobe");

    // Full-scale X plus a positive trim clips instead of wrapping negative
    a_sat_high_x: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_smp_valid && i_smp_raw[SAMPLE_W-1:0] == SAMPLE_W'(2**(SAMPLE_W-1)-1) &&
        !trim_q[0][TRIM_W-1] |=> o_smp_trim[SAMPLE_W-1:0] == SAMPLE_W'(2**(SAMPLE_W-1)-1))
        else $error("x high saturation wrong");

    // Most negative X plus a negative trim clips instead of wrapping positive
    a_sat_low_x: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_smp_valid && i_smp_raw[SAMPLE_W-1:0] == {1'b1, {(SAMPLE_W-1){1'b0}}} &&
        trim_q[0][TRIM_W-1] |=> o_smp_trim[SAMPLE_W-1:0] == {1'b1, {(SAMPLE_W-1){1'b0}}})
        else $error("x low saturation wrong");

    // Same clipping on the Z lane, positive side
    a_sat_high_z: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_smp_valid && i_smp_raw[2*SAMPLE_W +: SAMPLE_W] == SAMPLE_W'(2**(SAMPLE_W-1)-1) &&
        !trim_q[2][TRIM_W-1]
        |=> o_smp_trim[2*SAMPLE_W +: SAMPLE_W] == SAMPLE_W'(2**(SAMPLE_W-1)-1))
        else $error("z high saturation wrong");

    // Same clipping on the Y lane, negative side
    a_sat_low_y: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_smp_valid && i_smp_raw[SAMPLE_W +: SAMPLE_W] == {1'b1, {(SAMPLE_W-1){1'b0}}} &&
        trim_q[1][TRIM_W-1]
        |=> o_smp_trim[SAMPLE_W +: SAMPLE_W] == {1'b1, {(SAMPLE_W-1){1'b0}}})
        else $error("y low saturation wrong");

    // Zero trim leaves the Z sample untouched
    a_zero_trim_pass_z: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        i_smp_valid && trim_q[2] == 8'h00
        |=> o_smp_trim[2*SAMPLE_W +: SAMPLE_W] == $past(i_smp_raw[2*SAMPLE_W +: SAMPLE_W]))
        else $error("zero trim altered z sample");
endmodule

// ==== dv/aot_host.sv ====
`timescale 1ns/1ps
// Host end of the register port; data is inverted off the strobe so a stale byte never passes
module aot_host (
    input  wire logic       i_clk,
    output logic      [7:0] o_addr,
    output logic            o_wr,
    output logic      [7:0] o_wdata
);
    initial {o_addr, o_wr, o_wdata} = 17'h0;
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        {o_addr, o_wr, o_wdata} <= {a, w, d};
        @(posedge i_clk);
        {o_wr, o_wdata} <= {1'b0, ~d};
        #1;
    endtask
endmodule

// ==== dv/axis_offset_trim_tb.sv ====
`timescale 1ns/1ps
module axis_offset_trim_tb;
    import aot_pkg::*;
    logic        clk  = 1'b0;
    logic        rstn = 1'b0;
    logic        sv   = 1'b0;
    logic        wr, hit, ov;
    logic [7:0]  addr, wdata, rdata, d;
    logic [15:0] lfsr = 16'h887b;
    logic [23:0] tr   = 24'h0;
    logic [35:0] raw  = 36'h0;
    logic [35:0] trim, r;
    logic [35:0] expq[$];
    int          fail_count = 0;
    int          num_checks = 0;
    always #5 clk = ~clk;
    aot_host h (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_wdata(wdata));
    aot_axis_offset_trim DUT (.i_sys_clk(clk), .i_resetn(rstn), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_hit(hit),
        .i_smp_valid(sv), .i_smp_raw(raw), .o_smp_valid(ov), .o_smp_trim(trim));
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Reference: each axis gets trim times weight, clipped to the 12-bit signed span
    function automatic logic [35:0] model(input logic [35:0] x, input logic [23:0] t);
        int v;
        for (int i = 0; i < 3; i++) begin
            v = $signed(x[12*i+:12]) + (TRIM_MG_PER_LSB / SAMPLE_MG_PER_LSB) * $signed(t[8*i+:8]);
            v = v > 2047 ? 2047 : (v < -2048 ? -2048 : v);
            model[12*i+:12] = v[11:0];
        end
    endfunction
    task automatic chk(input string n, input logic [35:0] e, input logic [35:0] s);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Results pair with notes in arrival order, looked at once settled
    always @(negedge clk) if (ov === 1'b1) chk("sample", expq.pop_front(), trim);
    // Pass -1 reads reset values without writes and sends two samples at zero trim; passes 0 and 1 push trims and samples to both ends
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        for (int k = -1; k < 40; k++) begin
            for (int i = 0; i < 4; i++) begin
                lfsr = nxt(lfsr);
                d = k == 0 ? 8'h7f : (k == 1 ? 8'h80 : lfsr[7:0]);
                h.acc(k >= 0, 8'h2f + i[7:0], d);
                if (k >= 0 && i < 3) tr[8*i+:8] = d;
                chk("reg", {27'h0, i < 3, i < 3 ? tr[8*i+:8] : 8'h00}, {27'h0, hit, rdata});
            end
            // Two strobes back to back
            repeat (2) begin
                lfsr = nxt(lfsr);
                r = k == 0 ? 36'h7ff7ff7ff : (k == 1 ? 36'h800800800 : {lfsr[11:0], lfsr, lfsr[7:0]});
                @(posedge clk);
                sv  <= 1'b1;
                raw <= r;
                expq.push_back(model(r, tr));
            end
            @(posedge clk);
            sv <= 1'b0;
        end
        repeat (3) @(posedge clk);
        chk("drain", 36'h0, 36'(expq.size()));
        stop_test();
    end
endmodule
